// ===== cfs_pkg.sv
// constants and state types for the cec status flag block
package cfs_pkg;

    // register addresses on the plain register port
    localparam logic [7:0]  CFS_ADDR_TX_STATUS = 8'h10;
    localparam logic [7:0]  CFS_ADDR_RX_STATUS = 8'h12;
    localparam logic [7:0]  CFS_ADDR_TX_CTRL   = 8'h18;
    localparam logic [7:0]  CFS_ADDR_RX_CTRL   = 8'h1C;

    // transmit side status bit positions
    localparam int unsigned CFS_TX_FRAME_DONE  = 6;
    localparam int unsigned CFS_TX_FIFO_EMPTY  = 5;
    localparam int unsigned CFS_TX_CONTENTION  = 4;
    localparam int unsigned CFS_TX_ACK_ERROR   = 3;
    localparam int unsigned CFS_TX_UNDERRUN    = 2;
    localparam int unsigned CFS_TX_LOST_ARB    = 1;
    localparam int unsigned CFS_TX_BUS_IDLE    = 0;

    // receive side status bit positions
    localparam int unsigned CFS_RX_FRAME_DONE  = 6;
    localparam int unsigned CFS_RX_DATA_READY  = 5;
    localparam int unsigned CFS_RX_FIFO_FULL   = 4;
    localparam int unsigned CFS_RX_NOT_EMPTY   = 3;
    localparam int unsigned CFS_RX_TIMEOUT     = 2;
    localparam int unsigned CFS_RX_BUS_ERROR   = 1;
    localparam int unsigned CFS_RX_OVERRUN     = 0;

    // control register bit positions
    localparam int unsigned CFS_CTL_START      = 1;
    localparam int unsigned CFS_CTL_FLUSH      = 0;

    // which status bits are sticky write-one-to-clear flags
    localparam logic [15:0] CFS_TX_STICKY_MASK = 16'h005E;
    localparam logic [15:0] CFS_RX_STICKY_MASK = 16'h0067;
    // which control bits are interrupt enables
    localparam logic [15:0] CFS_TX_ENABLE_MASK = 16'h0060;
    localparam logic [15:0] CFS_RX_ENABLE_MASK = 16'h0070;

    // reset values
    localparam logic        CFS_TX_FIFO_EMPTY_RST = 1'b1;
    localparam logic        CFS_BUS_IDLE_RST      = 1'b1;
    localparam logic        CFS_BIT_ZERO          = 1'b0;
    localparam logic [15:0] CFS_WORD_ZERO         = 16'h0000;

    typedef struct packed {
        logic flag;
    } cfs_flag_state_t;

    typedef struct packed {
        logic [15:0] rd_data;
        logic        irq;
        logic [15:0] tx_enable;
        logic [15:0] rx_enable;
        logic        tx_fifo_empty;
        logic        bus_idle;
        logic        rx_fifo_full;
        logic        rx_fifo_not_empty;
        logic        tx_start;
        logic        tx_flush;
        logic        rx_flush;
    } cfs_state_t;

endpackage : cfs_pkg

// ===== cfs_flag.sv
// one sticky status flag: hardware sets, software clears, set wins
`timescale 1ns/10ps

module cfs_flag
#(
    parameter logic INIT = 1'b0
)
(
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // set and clear strobes
    input  wire logic set_i,
    input  wire logic clr_i,
    // flag value
    output logic      flag_o
);
    import cfs_pkg::*;

    cfs_flag_state_t st_r;
    cfs_flag_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        // an event in the clearing cycle must not be lost
        if (set_i)
        begin
            st_nxt.flag = 1'b1;
        end
        else if (clr_i)
        begin
            st_nxt.flag = 1'b0;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            st_r.flag <= INIT;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign flag_o = st_r.flag;

endmodule : cfs_flag

// ===== cfs_status.sv
// status flags, interrupt enables and register port of the cec controller
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps

module cfs_status
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    // transmit side events from the shifter and fifo
    input  wire logic        tx_block_sent_i,
    input  wire logic        tx_block_eom_i,
    input  wire logic        tx_fifo_push_i,
    input  wire logic        tx_fifo_pop_last_i,
    input  wire logic        tx_shift_need_i,
    input  wire logic        tx_conflict_i,
    input  wire logic        tx_arb_phase_i,
    input  wire logic        tx_ack_valid_i,
    input  wire logic        tx_ack_bit_i,
    input  wire logic        tx_broadcast_i,
    input  wire logic        bus_idle_i,
    // receive side events from the shifter and fifo
    input  wire logic        rx_fifo_push_i,
    input  wire logic        rx_block_eom_i,
    input  wire logic        rx_fifo_full_i,
    input  wire logic        rx_fifo_not_empty_i,
    input  wire logic        rx_timeout_i,
    input  wire logic        rx_spurious_i,
    // control pulses to the shifters and fifos
    output logic             tx_start_o,
    output logic             tx_flush_o,
    output logic             rx_flush_o,
    // interrupt
    output logic             irq_o
);
    import cfs_pkg::*;

    // all registered block state except the sticky flag cells lives in one struct
    cfs_state_t  st_r;
    cfs_state_t  st_nxt;

    // per-side set, clear, flag and read view words
    logic [15:0] tx_set;
    logic [15:0] tx_clr;
    logic [15:0] tx_flags;
    logic [15:0] rx_set;
    logic [15:0] rx_clr;
    logic [15:0] rx_flags;
    logic [15:0] tx_view;
    logic [15:0] rx_view;
    // decoded writes, line events and interrupt sources
    logic        wr_tx_status;
    logic        wr_rx_status;
    logic        wr_tx_ctrl;
    logic        wr_rx_ctrl;
    logic        tx_lab_ev;
    logic        tx_ce_ev;
    logic        tx_ack_ev;
    logic        tx_tx_underrun_ev;
    logic        rx_rx_overrun_ev;
    logic        tx_eom_ev;
    logic        tx_abort_ev;
    logic        rx_eom_ev;
    logic        rx_abort_ev;
    logic        tx_irq_any;
    logic        rx_irq_any;

    // address decode of writes; an unmapped offset selects nothing
    always_comb
    begin
        wr_tx_status = 1'b0;
        wr_rx_status = 1'b0;
        wr_tx_ctrl   = 1'b0;
        wr_rx_ctrl   = 1'b0;
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                CFS_ADDR_TX_STATUS:
                begin
                    wr_tx_status = 1'b1;
                end
                CFS_ADDR_RX_STATUS:
                begin
                    wr_rx_status = 1'b1;
                end
                CFS_ADDR_TX_CTRL:
                begin
                    wr_tx_ctrl = 1'b1;
                end
                CFS_ADDR_RX_CTRL:
                begin
                    wr_rx_ctrl = 1'b1;
                end
                default:
                begin
                    // writes to unmapped offsets are dropped
                end
            endcase
        end
    end

    // transmit error events
    assign tx_lab_ev   = tx_conflict_i && tx_arb_phase_i;
    assign tx_ce_ev    = tx_conflict_i && !tx_arb_phase_i;
    // broadcast expects a one acknowledge and a zero refuses it, directed a one is a nack
    assign tx_ack_ev   = tx_ack_valid_i
                       && (tx_broadcast_i ? !tx_ack_bit_i : tx_ack_bit_i);
    // underrun looks at the registered empty flag, not its next value
    assign tx_tx_underrun_ev = tx_shift_need_i && st_r.tx_fifo_empty;

    // receive error event: a push into a full fifo
    assign rx_rx_overrun_ev  = rx_fifo_push_i && rx_fifo_full_i;

    // frame ends: the marked last block, or any abort of that side
    assign tx_eom_ev   = tx_block_sent_i && tx_block_eom_i;
    assign tx_abort_ev = tx_lab_ev || tx_ce_ev || tx_ack_ev || tx_tx_underrun_ev;
    assign rx_eom_ev   = rx_fifo_push_i && rx_block_eom_i;
    assign rx_abort_ev = rx_rx_overrun_ev || rx_timeout_i || rx_spurious_i;

    always_comb
    begin
        tx_set                    = CFS_WORD_ZERO;
        tx_set[CFS_TX_LOST_ARB]   = tx_lab_ev;
        tx_set[CFS_TX_CONTENTION] = tx_ce_ev;
        tx_set[CFS_TX_ACK_ERROR]  = tx_ack_ev;
        tx_set[CFS_TX_UNDERRUN]   = tx_tx_underrun_ev;
        // done fires on the eom block or on any aborting error
        tx_set[CFS_TX_FRAME_DONE] = tx_eom_ev || tx_abort_ev;
    end

    always_comb
    begin
        rx_set                    = CFS_WORD_ZERO;
        rx_set[CFS_RX_OVERRUN]    = rx_rx_overrun_ev;
        rx_set[CFS_RX_TIMEOUT]    = rx_timeout_i;
        rx_set[CFS_RX_BUS_ERROR]  = rx_spurious_i;
        rx_set[CFS_RX_DATA_READY] = rx_fifo_push_i;
        rx_set[CFS_RX_FRAME_DONE] = rx_eom_ev || rx_abort_ev;
    end

    // write one clears, write zero leaves the flag alone
    // level bits ignore the write, they follow their sources
    always_comb
    begin
        tx_clr = CFS_WORD_ZERO;
        rx_clr = CFS_WORD_ZERO;
        if (wr_tx_status)
        begin
            tx_clr = reg_wdata_i & CFS_TX_STICKY_MASK;
        end
        if (wr_rx_status)
        begin
            rx_clr = reg_wdata_i & CFS_RX_STICKY_MASK;
        end
    end

    // one sticky cell per flag position; other positions read zero
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_flag
            if (CFS_TX_STICKY_MASK[gi])
            begin : g_tx
                cfs_flag
                #(
                    .INIT   (CFS_BIT_ZERO)
                )
                u_tx_flag
                (
                    .mclk_i (mclk_i),
                    .rst_i  (rst_i),
                    .set_i  (tx_set[gi]),
                    .clr_i  (tx_clr[gi]),
                    .flag_o (tx_flags[gi])
                );
            end
            else
            begin : g_tx_none
                assign tx_flags[gi] = 1'b0;
            end
            if (CFS_RX_STICKY_MASK[gi])
            begin : g_rx
                cfs_flag
                #(
                    .INIT   (CFS_BIT_ZERO)
                )
                u_rx_flag
                (
                    .mclk_i (mclk_i),
                    .rst_i  (rst_i),
                    .set_i  (rx_set[gi]),
                    .clr_i  (rx_clr[gi]),
                    .flag_o (rx_flags[gi])
                );
            end
            else
            begin : g_rx_none
                assign rx_flags[gi] = 1'b0;
            end
        end
    endgenerate

    // register views merge sticky flags with live level bits
    always_comb
    begin
        tx_view                    = tx_flags;
        tx_view[CFS_TX_FIFO_EMPTY] = st_r.tx_fifo_empty;
        tx_view[CFS_TX_BUS_IDLE]   = st_r.bus_idle;
    end

    always_comb
    begin
        rx_view                    = rx_flags;
        rx_view[CFS_RX_FIFO_FULL]  = st_r.rx_fifo_full;
        rx_view[CFS_RX_NOT_EMPTY]  = st_r.rx_fifo_not_empty;
    end

    // full is a level, so its interrupt lasts as long as the fifo stays full
    assign tx_irq_any = |(tx_view & st_r.tx_enable);
    assign rx_irq_any = |(rx_view & st_r.rx_enable);

    always_comb
    begin
        st_nxt = st_r;

        // level inputs are sampled so the status reads from flops
        st_nxt.bus_idle          = bus_idle_i;
        st_nxt.rx_fifo_full      = rx_fifo_full_i;
        st_nxt.rx_fifo_not_empty = rx_fifo_not_empty_i;

        // fifo empty: a new entry clears it, the last pop or a flush sets it;
        // a push beside the last pop leaves one entry, so the push wins
        if (tx_fifo_push_i)
        begin
            st_nxt.tx_fifo_empty = 1'b0;
        end
        else if (tx_fifo_pop_last_i || st_r.tx_flush)
        begin
            st_nxt.tx_fifo_empty = 1'b1;
        end

        // control: enables are stored, start and flush self-clear;
        // a held pulse would restart a frame or flush the fifo again
        st_nxt.tx_start = 1'b0;
        st_nxt.tx_flush = 1'b0;
        st_nxt.rx_flush = 1'b0;
        if (wr_tx_ctrl)
        begin
            st_nxt.tx_enable = reg_wdata_i & CFS_TX_ENABLE_MASK;
            st_nxt.tx_start  = reg_wdata_i[CFS_CTL_START];
            st_nxt.tx_flush  = reg_wdata_i[CFS_CTL_FLUSH];
        end
        if (wr_rx_ctrl)
        begin
            st_nxt.rx_enable = reg_wdata_i & CFS_RX_ENABLE_MASK;
            st_nxt.rx_flush  = reg_wdata_i[CFS_CTL_FLUSH];
        end

        // read data stand only in the cycle after the read strobe
        st_nxt.rd_data = CFS_WORD_ZERO;
        if (reg_rd_i)
        begin
            // control offsets read back their enables only, pulses read zero
            unique case (reg_addr_i)
                CFS_ADDR_TX_STATUS:
                begin
                    st_nxt.rd_data = tx_view;
                end
                CFS_ADDR_RX_STATUS:
                begin
                    st_nxt.rd_data = rx_view;
                end
                CFS_ADDR_TX_CTRL:
                begin
                    st_nxt.rd_data = st_r.tx_enable;
                end
                CFS_ADDR_RX_CTRL:
                begin
                    st_nxt.rd_data = st_r.rx_enable;
                end
                default:
                begin
                    st_nxt.rd_data = CFS_WORD_ZERO;
                end
            endcase
        end

        // each enabled flag drives the single level interrupt
        st_nxt.irq = tx_irq_any || rx_irq_any;
    end

    // reset is synchronous; level bits restart at their idle values
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            st_r.rd_data           <= CFS_WORD_ZERO;
            st_r.irq               <= CFS_BIT_ZERO;
            st_r.tx_enable         <= CFS_WORD_ZERO;
            st_r.rx_enable         <= CFS_WORD_ZERO;
            st_r.tx_fifo_empty     <= CFS_TX_FIFO_EMPTY_RST;
            st_r.bus_idle          <= CFS_BUS_IDLE_RST;
            st_r.rx_fifo_full      <= CFS_BIT_ZERO;
            st_r.rx_fifo_not_empty <= CFS_BIT_ZERO;
            st_r.tx_start          <= CFS_BIT_ZERO;
            st_r.tx_flush          <= CFS_BIT_ZERO;
            st_r.rx_flush          <= CFS_BIT_ZERO;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rd_data;
    assign irq_o       = st_r.irq;
    assign tx_start_o  = st_r.tx_start;
    assign tx_flush_o  = st_r.tx_flush;
    assign rx_flush_o  = st_r.rx_flush;

endmodule : cfs_status

// ===== cfs_status_monitor.sv
// concurrent checks on the ports of the cec status flag block
`timescale 1ns/10ps

module cfs_status_monitor
(
    // clock, reset and register port
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // line and fifo events
    input wire logic        tx_conflict_i,
    input wire logic        tx_arb_phase_i,
    input wire logic        tx_ack_valid_i,
    input wire logic        tx_ack_bit_i,
    input wire logic        tx_broadcast_i,
    input wire logic        bus_idle_i,
    input wire logic        rx_fifo_push_i,
    input wire logic        rx_fifo_full_i,
    input wire logic        rx_fifo_not_empty_i,
    input wire logic        rx_timeout_i,
    input wire logic        rx_spurious_i
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_rd_tx;
        reg_rd_i && reg_addr_i == 8'h10;
    endsequence

    sequence s_rd_rx;
        reg_rd_i && reg_addr_i == 8'h12;
    endsequence

    // an event must be visible to a read issued in the very next cycle
    a_lost_arb_set: assert property (tx_conflict_i && tx_arb_phase_i ##1 s_rd_tx |=>
        reg_rdata_o[1] && reg_rdata_o[6]) else $error("lost arbitration not flagged");
    a_contention_set: assert property (tx_conflict_i && !tx_arb_phase_i ##1 s_rd_tx |=>
        reg_rdata_o[4] && reg_rdata_o[6]) else $error("contention not flagged");
    a_ack_err_set: assert property (tx_ack_valid_i && tx_ack_bit_i != tx_broadcast_i
        ##1 s_rd_tx |=> reg_rdata_o[3] && reg_rdata_o[6]) else $error("ack error missed");
    a_data_ready_set: assert property (rx_fifo_push_i ##1 s_rd_rx |=>
        reg_rdata_o[5]) else $error("data ready not flagged");
    a_overrun_set: assert property (rx_fifo_push_i && rx_fifo_full_i ##1 s_rd_rx |=>
        reg_rdata_o[0] && reg_rdata_o[6]) else $error("overrun not flagged");
    a_timeout_set: assert property (rx_timeout_i ##1 s_rd_rx |=>
        reg_rdata_o[2] && reg_rdata_o[6]) else $error("bus timeout not flagged");
    a_bus_err_set: assert property (rx_spurious_i ##1 s_rd_rx |=>
        reg_rdata_o[1] && reg_rdata_o[6]) else $error("bus error not flagged");
    // level bits lag their inputs by one register stage
    a_idle_level: assert property (reg_rd_i && reg_addr_i == 8'h10 && !$past(rst_i) |=>
        reg_rdata_o[0] == $past(bus_idle_i, 2)) else $error("idle bit wrong");
    a_rx_levels: assert property (s_rd_rx ##0 !$past(rst_i) |=>
        reg_rdata_o[4:3] == {$past(rx_fifo_full_i, 2), $past(rx_fifo_not_empty_i, 2)})
        else $error("fifo level bits wrong");
endmodule : cfs_status_monitor

bind cfs_status cfs_status_monitor u_mon (.mclk_i(mclk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .tx_conflict_i(tx_conflict_i), .tx_arb_phase_i(tx_arb_phase_i),
    .tx_ack_valid_i(tx_ack_valid_i), .tx_ack_bit_i(tx_ack_bit_i),
    .tx_broadcast_i(tx_broadcast_i), .bus_idle_i(bus_idle_i),
    .rx_fifo_push_i(rx_fifo_push_i), .rx_fifo_full_i(rx_fifo_full_i),
    .rx_fifo_not_empty_i(rx_fifo_not_empty_i), .rx_timeout_i(rx_timeout_i),
    .rx_spurious_i(rx_spurious_i));

// ===== cfs_cec_peer.sv
// behavioural model of the other devices sharing the cec line
`timescale 1ns/10ps

module cfs_cec_peer
(
    // clock
    input  wire logic mclk_i,
    // line conditions seen by the controller
    output logic      bus_idle_o = 1'b1,
    output logic      tx_conflict_o = 1'b0,
    output logic      tx_ack_bit_o = 1'b0,
    output logic      rx_timeout_o = 1'b0,
    output logic      rx_spurious_o = 1'b0,
    output logic      rx_block_eom_o = 1'b0
);
    int          seed = 7211;
    logic [31:0] r;

    always @(posedge mclk_i)
    begin
        r = $random(seed);
        bus_idle_o     <= r[0] | r[1];
        tx_conflict_o  <= &r[4:2];
        // followers acknowledge or refuse at random, so both ack polarities occur
        tx_ack_bit_o   <= r[5];
        rx_timeout_o   <= &r[9:6];
        rx_spurious_o  <= &r[13:10];
        rx_block_eom_o <= r[14] & r[15];
    end
endmodule : cfs_cec_peer

// ===== testbench.sv
// self-checking bench for the cec status flag block
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value at %0t: %h expected %h", $time, got, exp); end end

module testbench;
    logic        mclk_i = 0;
    logic        rst_i = 1;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic        reg_wr_i = 0, reg_rd_i = 0, tx_block_sent_i = 0, tx_block_eom_i = 0;
    logic        tx_fifo_push_i = 0, tx_fifo_pop_last_i = 0, tx_shift_need_i = 0;
    logic        tx_arb_phase_i = 0, tx_ack_valid_i = 0, tx_broadcast_i = 0;
    logic        rx_fifo_push_i = 0, rx_fifo_full_i = 0, rx_fifo_not_empty_i = 0;
    logic        bus_idle_i, tx_conflict_i, tx_ack_bit_i, rx_timeout_i, rx_spurious_i;
    logic        rx_block_eom_i, tx_start_o, tx_flush_o, rx_flush_o, irq_o;
    logic [15:0] reg_rdata_o, tx_m, rx_m, en_t, en_r, exp_rd;
    logic [2:0]  pend;
    logic        chk_rd, irq_q;
    int          n_fail = 0, checked = 0, seed = 52588;
    logic [7:0]  addr_tab [5] = '{8'h10, 8'h12, 8'h18, 8'h1C, 8'h16};

    cfs_status DUT (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .tx_block_sent_i(tx_block_sent_i),
        .tx_block_eom_i(tx_block_eom_i), .tx_fifo_push_i(tx_fifo_push_i),
        .tx_fifo_pop_last_i(tx_fifo_pop_last_i), .tx_shift_need_i(tx_shift_need_i),
        .tx_conflict_i(tx_conflict_i), .tx_arb_phase_i(tx_arb_phase_i),
        .tx_ack_valid_i(tx_ack_valid_i), .tx_ack_bit_i(tx_ack_bit_i),
        .tx_broadcast_i(tx_broadcast_i), .bus_idle_i(bus_idle_i),
        .rx_fifo_push_i(rx_fifo_push_i), .rx_block_eom_i(rx_block_eom_i),
        .rx_fifo_full_i(rx_fifo_full_i), .rx_fifo_not_empty_i(rx_fifo_not_empty_i),
        .rx_timeout_i(rx_timeout_i), .rx_spurious_i(rx_spurious_i),
        .tx_start_o(tx_start_o), .tx_flush_o(tx_flush_o), .rx_flush_o(rx_flush_o),
        .irq_o(irq_o));
    cfs_cec_peer u_peer (.mclk_i, .bus_idle_o(bus_idle_i), .tx_conflict_o(tx_conflict_i),
        .tx_ack_bit_o(tx_ack_bit_i), .rx_timeout_o(rx_timeout_i),
        .rx_spurious_o(rx_spurious_i), .rx_block_eom_o(rx_block_eom_i));

    initial forever #10 mclk_i = ~mclk_i;

    task automatic end_sim;
        $display("mismatches %0d, comparisons %0d", n_fail, checked);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // reference model: inputs are read before this edge's new drives land
    always @(posedge mclk_i)
    begin : model
        logic [15:0] ts, rs;
        logic        w18, w1c;
        w18 = reg_wr_i && reg_addr_i == 8'h18;
        w1c = reg_wr_i && reg_addr_i == 8'h1C;
        if (rst_i)
        begin
            {tx_m, rx_m, en_t, en_r} = {16'h0021, 48'h0};
            {pend, irq_q, chk_rd} = 5'h00;
        end
        else
        begin
            `CHK({tx_start_o, tx_flush_o, rx_flush_o, irq_o}, {pend, irq_q})
            `CHK(reg_rdata_o, chk_rd ? exp_rd : 16'h0000)
            irq_q = |(tx_m & en_t) || |(rx_m & en_r);
            chk_rd = reg_rd_i;
            exp_rd = reg_addr_i == 8'h10 ? tx_m : reg_addr_i == 8'h12 ? rx_m :
                     reg_addr_i == 8'h18 ? en_t : reg_addr_i == 8'h1C ? en_r : 16'h0000;
            ts = tx_m;
            rs = rx_m;
            if (reg_wr_i && reg_addr_i == 8'h10) ts &= ~(reg_wdata_i & 16'h005E);
            if (reg_wr_i && reg_addr_i == 8'h12) rs &= ~(reg_wdata_i & 16'h0067);
            if (tx_shift_need_i && tx_m[5]) ts |= 16'h0044;
            if (tx_conflict_i) ts |= tx_arb_phase_i ? 16'h0042 : 16'h0050;
            if (tx_ack_valid_i && tx_ack_bit_i != tx_broadcast_i) ts |= 16'h0048;
            if (tx_block_sent_i && tx_block_eom_i) ts |= 16'h0040;
            ts[5] = (tx_m[5] | tx_fifo_pop_last_i | pend[1]) & ~tx_fifo_push_i;
            ts[0] = bus_idle_i;
            if (rx_fifo_push_i) rs |= rx_block_eom_i ? 16'h0060 : 16'h0020;
            if (rx_fifo_push_i && rx_fifo_full_i) rs |= 16'h0041;
            if (rx_timeout_i) rs |= 16'h0044;
            if (rx_spurious_i) rs |= 16'h0042;
            rs[4:3] = {rx_fifo_full_i, rx_fifo_not_empty_i};
            pend = {w18 & reg_wdata_i[1], w18 & reg_wdata_i[0], w1c & reg_wdata_i[0]};
            if (w18) en_t = reg_wdata_i & 16'h0060;
            if (w1c) en_r = reg_wdata_i & 16'h0070;
            tx_m = ts;
            rx_m = rs;
        end
    end

    initial
    begin
        logic [31:0] p, l;
        // two passes, so a reset in mid-run is exercised as well
        for (int r = 0; r < 2; r++)
        begin
            @(posedge mclk_i);
            rst_i <= 1;
            {reg_rd_i, reg_wr_i} <= 2'b00;
            repeat (9) @(posedge mclk_i);
            rst_i <= 0;
            for (int i = 0; i < 3000; i++)
            begin
                @(posedge mclk_i);
                // three ands make each event pulse rare, about one cycle in eight
                p = $random(seed) & $random(seed) & $random(seed);
                l = $random(seed);
                {tx_block_sent_i, tx_fifo_push_i, tx_fifo_pop_last_i} <= p[2:0];
                {tx_shift_need_i, tx_ack_valid_i, rx_fifo_push_i} <= p[5:3];
                {tx_block_eom_i, tx_arb_phase_i, tx_broadcast_i} <= l[2:0];
                {rx_fifo_full_i, rx_fifo_not_empty_i} <= l[4:3];
                reg_rd_i <= l[7:5] < 3;
                reg_wr_i <= l[7:5] == 3;
                reg_addr_i <= addr_tab[l[10:8] % 5];
                reg_wdata_i <= l[31:16];
            end
        end
        end_sim();
    end

    initial
    begin
        #160000;
        n_fail++;
        end_sim();
    end
endmodule : testbench
